// ---- rtl/hppic_regs.svh ----
// Register map, field positions, reset values and timing constants
`ifndef HPPIC_REGS_SVH
`define HPPIC_REGS_SVH

// ============================================================
// Register offsets (byte addresses)
`define HPPIC_CTRL_OFS      8'h00
`define HPPIC_OCTIME_OFS    8'h04
`define HPPIC_POWER_OFS     8'h08
`define HPPIC_INDCTL_OFS    8'h0c
`define HPPIC_STATUS_OFS    8'h10
`define HPPIC_HUBCHAR_OFS   8'h14

// ============================================================
// Field positions
`define HPPIC_CTRL_SW_LSB   0
`define HPPIC_CTRL_SW_MSB   1
`define HPPIC_CTRL_FSONLY   2
`define HPPIC_CTRL_INDPRES  3
`define HPPIC_OCT_EN_LSB    0
`define HPPIC_OCT_EN_MSB    3
`define HPPIC_OCT_DIS_LSB   4
`define HPPIC_OCT_DIS_MSB   7
`define HPPIC_PWR_SET_LSB   0
`define HPPIC_PWR_SET_MSB   3
`define HPPIC_PWR_CLR_LSB   4
`define HPPIC_PWR_CLR_MSB   7
`define HPPIC_PWR_OCACT_LSB 8
`define HPPIC_PWR_OCACT_MSB 11
`define HPPIC_ST_OC_LSB     0
`define HPPIC_ST_OC_MSB     3
`define HPPIC_ST_BAB_LSB    4
`define HPPIC_ST_BAB_MSB    7
`define HPPIC_IND_FLD_W     4
`define HPPIC_IND_MAN_BIT   3
`define HPPIC_HC_IND_BIT    7

// ============================================================
// Reset values
`define HPPIC_SW_RESET      2'h1
`define HPPIC_OC_MS_RESET   4'h8
`define HPPIC_INDPRES_RESET 1'h1

// ============================================================
// Timing
`define HPPIC_CLK_PERIOD_NS 10
`define HPPIC_TICK_NS       1000000
`define HPPIC_BLINK_MS      500

`endif

// ---- rtl/hppic_pkg.sv ----
// Types shared by the port power and indicator control block
package hppic_pkg;

    // Port state group reported by the port state machine
    typedef enum logic [1:0] {
        HPPIC_ST_POWERED_OFF = 2'h0,
        HPPIC_ST_INACTIVE    = 2'h1,
        HPPIC_ST_ENABLED     = 2'h2,
        HPPIC_ST_SUSPENDED   = 2'h3
    } hppic_port_state_e;

    // Power switching arrangement
    typedef enum logic [1:0] {
        HPPIC_SW_GANGED  = 2'h0,
        HPPIC_SW_PERPORT = 2'h1,
        HPPIC_SW_NONE    = 2'h2,
        HPPIC_SW_RSVD    = 2'h3
    } hppic_sw_mode_e;

    // Manual indicator selection
    typedef enum logic [2:0] {
        HPPIC_IND_OFF         = 3'h0,
        HPPIC_IND_AMBER       = 3'h1,
        HPPIC_IND_GREEN       = 3'h2,
        HPPIC_IND_BLINK_GREEN = 3'h3,
        HPPIC_IND_BLINK_AMBER = 3'h4,
        HPPIC_IND_BLINK_BOTH  = 3'h5,
        HPPIC_IND_RSVD6       = 3'h6,
        HPPIC_IND_RSVD7       = 3'h7
    } hppic_ind_code_e;

    // Overcurrent qualification intervals in milliseconds
    typedef struct packed {
        logic [3:0] en_ms;
        logic [3:0] dis_ms;
    } hppic_oc_cfg_s;

endpackage

// ---- rtl/hppic_oc_qual.sv ----
// Overcurrent qualification timer for one port
module hppic_oc_qual (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sense_n_i,
    input wire logic tick_i,
    input wire logic port_en_i,
    input wire hppic_pkg::hppic_oc_cfg_s cfg_i,
    output logic qual_o
);
    import hppic_pkg::*;

    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic qual_d;
    wire [3:0] thr = port_en_i ? cfg_i.en_ms : cfg_i.dis_ms; // RQ9
    wire done = (cnt_q >= thr);

    // Ticks are free running, so the interval is accurate to one tick
    assign cnt_d = sense_n_i ? 4'h0 : ((tick_i && !done) ? cnt_q + 4'h1 : cnt_q); // RQ8
    assign qual_d = !sense_n_i && done;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 4'h0;
            qual_o <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            qual_o <= qual_d;
        end
    end

    oc_release_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ8
        sense_n_i |=> !qual_o)
        else $error("overcurrent stayed qualified after sense released");
    oc_zero_ms_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ9
        (!sense_n_i && thr == 4'h0) |=> qual_o)
        else $error("zero interval did not qualify at once");

endmodule

// ---- rtl/hppic_led.sv ----
// Green and amber indicator driver for one port
module hppic_led (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic present_i,
    input wire logic manual_i,
    input wire hppic_pkg::hppic_ind_code_e code_i,
    input wire hppic_pkg::hppic_port_state_e state_i,
    input wire logic oc_amber_i,
    input wire logic no_switch_i,
    input wire logic reset_req_i,
    input wire logic blink_i,
    output logic green_o,
    output logic amber_o
);
    import hppic_pkg::*;

    logic rst_green_q;
    logic green_d;
    logic amber_d;
    logic auto_g;
    logic auto_a;
    logic man_g;
    logic man_a;

    // Reset lighting holds until the port leaves the resetting group
    wire rst_green_d = reset_req_i | (rst_green_q && state_i == HPPIC_ST_INACTIVE); // RQ21

    always_comb begin
        auto_g = 1'b0;
        auto_a = 1'b0;
        unique case (state_i) // RQ17
            HPPIC_ST_POWERED_OFF: auto_a = oc_amber_i;
            HPPIC_ST_INACTIVE: begin
                auto_a = oc_amber_i && no_switch_i;
                auto_g = rst_green_q && !auto_a;
            end
            HPPIC_ST_ENABLED: auto_g = 1'b1; // RQ15
            HPPIC_ST_SUSPENDED: auto_g = 1'b0;
        endcase
    end

    always_comb begin
        man_g = 1'b0;
        man_a = 1'b0;
        unique case (code_i) // RQ18
            HPPIC_IND_AMBER: man_a = 1'b1;
            HPPIC_IND_GREEN: man_g = 1'b1;
            HPPIC_IND_BLINK_GREEN: man_g = blink_i;
            HPPIC_IND_BLINK_AMBER: man_a = blink_i;
            HPPIC_IND_BLINK_BOTH: begin
                man_g = blink_i;
                man_a = !blink_i;
            end
            default: begin
                man_g = 1'b0;
                man_a = 1'b0;
            end
        endcase
    end

    // Automatic path never reads the blink phase
    assign green_d = present_i && (manual_i ? man_g : auto_g); // RQ16
    assign amber_d = present_i && (manual_i ? man_a : auto_a); // RQ14

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_green_q <= 1'b0;
            green_o <= 1'b0;
            amber_o <= 1'b0;
        end else begin
            rst_green_q <= rst_green_d;
            green_o <= green_d;
            amber_o <= amber_d;
        end
    end

    led_one_lit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ18
        !(green_o && amber_o))
        else $error("both indicator leds lit");
    auto_enabled_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ15
        (present_i && !manual_i && state_i == HPPIC_ST_ENABLED) |=> green_o && !amber_o)
        else $error("enabled port not steady green in automatic mode");

endmodule

// ---- rtl/hppic_top.sv ----
// Hub downstream port power, overcurrent, indicator and upstream monitor control
`include "hppic_regs.svh"

// Behaviour
// RQ1: Upstream speed high unless full-speed-only set
// RQ2: Block downstream babble/disconnect from upstream
// RQ3: Babble disconnects only the offending port
// RQ4: Ganged or per-port switching, per-port default
// RQ5: Ports start unpowered; host powers each
// RQ6: Active-low power enable output per port
// RQ7: Switch drives active-low overcurrent per port
// RQ8: Overcurrent qualified by timer, default 8 ms
// RQ9: Interval 0-15 ms, enabled/disabled separately
// RQ10: Qualified overcurrent reported, port power removed
// RQ11: Indicator presence in characteristic bit 7
// RQ12: Configuration clears indicator bit without LEDs
// RQ13: Two LEDs per port, green and amber
// RQ14: Automatic indicator mode after power-up
// RQ15: Auto: green enabled, amber on overcurrent
// RQ16: No blinking in automatic mode
// RQ17: Auto colour follows port state table
// RQ18: Manual: host picks one LED, blinking allowed
// RQ19: Manual colour meanings defined by host software
// RQ20: Host blinks green on babble, amber overcurrent
// RQ21: Port reset lights green unless overridden
// RQ22: Babble on enabled port disables it
// RQ23: Ganged mode switches and trips all ports
module hppic_top #(
    parameter int NPORTS = 4,
    parameter int TICK_CYCLES = `HPPIC_TICK_NS / `HPPIC_CLK_PERIOD_NS,
    parameter int BLINK_TICKS = `HPPIC_BLINK_MS
) (
    input wire logic CLK_SYS_I,
    input wire logic RESET_N_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WE_I,
    input wire logic REG_RE_I,
    output logic [31:0] REG_RDATA_O,
    input wire hppic_pkg::hppic_port_state_e [NPORTS-1:0] PORT_STATE_I,
    input wire logic [NPORTS-1:0] PORT_RESET_REQ_I,
    input wire logic [NPORTS-1:0] BABBLE_I,
    input wire logic [NPORTS-1:0] DS_DISCONNECT_I,
    input wire logic [NPORTS-1:0] DS_SOURCE_I,
    input wire logic US_RPT_CONN_I,
    input wire logic US_TX_REQ_I,
    input wire logic US_CHIRP_OK_I,
    input wire logic [NPORTS-1:0] PORT_OVERCURRENT_SENSE_N_I,
    output logic [NPORTS-1:0] PORT_POWER_ENABLE_N_O,
    output logic [NPORTS-1:0] PORT_DISABLE_O,
    output logic [NPORTS-1:0] OC_REPORT_O,
    output logic US_TX_EN_O,
    output logic US_HIGH_SPEED_O,
    output logic [NPORTS-1:0] LED_GREEN_O,
    output logic [NPORTS-1:0] LED_AMBER_O
);
    import hppic_pkg::*;

    // ============================================================
    // Register state
    logic [1:0] sw_mode_q;
    logic fs_only_q;
    logic ind_pres_q;
    hppic_oc_cfg_s oc_cfg_q;
    logic [4*NPORTS-1:0] indctl_q;
    logic [NPORTS-1:0] power_q;
    logic [NPORTS-1:0] oc_amber_q;
    logic [NPORTS-1:0] oc_chg_q;
    logic [NPORTS-1:0] bab_chg_q;
    logic [NPORTS-1:0] blocked_q;
    logic [NPORTS-1:0] qual_q;
    logic [31:0] rdata_d;

    // ============================================================
    // Decode
    wire wr_ctrl = REG_WE_I && REG_ADDR_I == `HPPIC_CTRL_OFS;
    wire wr_oct = REG_WE_I && REG_ADDR_I == `HPPIC_OCTIME_OFS;
    wire wr_pwr = REG_WE_I && REG_ADDR_I == `HPPIC_POWER_OFS;
    wire wr_ind = REG_WE_I && REG_ADDR_I == `HPPIC_INDCTL_OFS;
    wire wr_st = REG_WE_I && REG_ADDR_I == `HPPIC_STATUS_OFS;
    wire ganged = sw_mode_q == HPPIC_SW_GANGED;
    wire no_switch = sw_mode_q == HPPIC_SW_NONE;

    // ============================================================
    // Overcurrent input synchronisers, two stages
    // Pins idle high, so both stages reset to the released level
    logic [NPORTS-1:0] oc_meta_q;
    logic [NPORTS-1:0] oc_sync_q;
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            oc_meta_q <= {NPORTS{1'b1}};
            oc_sync_q <= {NPORTS{1'b1}};
        end else begin
            oc_meta_q <= PORT_OVERCURRENT_SENSE_N_I; // RQ7
            oc_sync_q <= oc_meta_q;
        end
    end

    // ============================================================
    // Millisecond tick and blink phase
    // Blink shares the tick, so its own divider counts ticks, not clocks
    logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_q;
    logic [$clog2(BLINK_TICKS+1)-1:0] blink_cnt_q;
    logic blink_q;
    wire tick = tick_cnt_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1);
    wire blink_wrap = tick && blink_cnt_q == ($clog2(BLINK_TICKS+1))'(BLINK_TICKS - 1);
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            tick_cnt_q <= '0;
            blink_cnt_q <= '0;
            blink_q <= 1'b0;
        end else begin
            tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
            blink_cnt_q <= blink_wrap ? '0 : (tick ? blink_cnt_q + 1'b1 : blink_cnt_q);
            blink_q <= blink_wrap ? !blink_q : blink_q;
        end
    end

    // ============================================================
    // Per-port qualifiers and indicator drivers
    logic [NPORTS-1:0] qual;
    genvar gi;
    generate
        for (gi = 0; gi < NPORTS; gi++) begin : g_port
            hppic_oc_qual u_qual (
                .clk_i(CLK_SYS_I),
                .rst_n_i(RESET_N_I),
                .sense_n_i(oc_sync_q[gi]),
                .tick_i(tick),
                .port_en_i(PORT_STATE_I[gi] == HPPIC_ST_ENABLED),
                .cfg_i(oc_cfg_q),
                .qual_o(qual[gi])
            );
            hppic_led u_led (
                .clk_i(CLK_SYS_I),
                .rst_n_i(RESET_N_I),
                .present_i(ind_pres_q),
                .manual_i(indctl_q[gi*`HPPIC_IND_FLD_W+`HPPIC_IND_MAN_BIT]),
                .code_i(hppic_ind_code_e'(indctl_q[gi*4 +: 3])),
                .state_i(PORT_STATE_I[gi]),
                .oc_amber_i(oc_amber_q[gi]),
                .no_switch_i(no_switch),
                .reset_req_i(PORT_RESET_REQ_I[gi]),
                .blink_i(blink_q),
                .green_o(LED_GREEN_O[gi]), // RQ13
                .amber_o(LED_AMBER_O[gi])
            );
        end
    endgenerate

    // ============================================================
    // Power switching
    wire [NPORTS-1:0] qual_rise = qual & ~qual_q;
    wire [NPORTS-1:0] set_raw = wr_pwr ? REG_WDATA_I[`HPPIC_PWR_SET_MSB:`HPPIC_PWR_SET_LSB] : '0;
    wire [NPORTS-1:0] clr_raw = wr_pwr ? REG_WDATA_I[`HPPIC_PWR_CLR_MSB:`HPPIC_PWR_CLR_LSB] : '0;
    wire [NPORTS-1:0] pw_set = ganged ? {NPORTS{|set_raw}} : set_raw; // RQ23
    wire [NPORTS-1:0] pw_clr = ganged ? {NPORTS{|clr_raw}} : clr_raw;
    wire [NPORTS-1:0] oc_trip = ganged ? {NPORTS{|qual_rise}} : qual_rise; // RQ23
    // Trip wins over a host power request in the same cycle
    wire [NPORTS-1:0] pw_base = ((power_q | pw_set) & ~pw_clr) & ~oc_trip; // RQ10
    // Entering ganged mode with mixed power drops every port together
    wire [NPORTS-1:0] power_d = ganged ? {NPORTS{&pw_base}} : pw_base; // RQ23
    wire [NPORTS-1:0] pwr_en_n_d = no_switch ? '0 : ~power_d; // RQ6
    wire [NPORTS-1:0] amber_d = oc_trip | (oc_amber_q & ~pw_set);
    wire [NPORTS-1:0] st_clr_oc = wr_st ? REG_WDATA_I[`HPPIC_ST_OC_MSB:`HPPIC_ST_OC_LSB] : '0;
    wire [NPORTS-1:0] st_clr_bab = wr_st ? REG_WDATA_I[`HPPIC_ST_BAB_MSB:`HPPIC_ST_BAB_LSB] : '0;
    wire [NPORTS-1:0] oc_chg_d = oc_trip | (oc_chg_q & ~st_clr_oc); // RQ10

    // ============================================================
    // Babble handling and upstream monitor
    logic [NPORTS-1:0] port_en;
    always_comb begin
        for (int i = 0; i < NPORTS; i++) begin
            port_en[i] = PORT_STATE_I[i] == HPPIC_ST_ENABLED;
        end
    end
    wire [NPORTS-1:0] bab_dis = BABBLE_I & port_en; // RQ22
    wire [NPORTS-1:0] bad_now = BABBLE_I | DS_DISCONNECT_I;
    // A blocked source stays blocked until the host resets that port
    wire [NPORTS-1:0] blocked_d = bad_now | (blocked_q & ~PORT_RESET_REQ_I); // RQ3
    wire [NPORTS-1:0] clean_src = DS_SOURCE_I & ~blocked_q & ~bad_now;
    wire tx_en_d = US_RPT_CONN_I && US_TX_REQ_I && (|clean_src); // RQ2
    wire hs_d = US_CHIRP_OK_I && !fs_only_q; // RQ1
    wire [NPORTS-1:0] bab_chg_d = bab_dis | (bab_chg_q & ~st_clr_bab);

    // ============================================================
    // Read mux
    wire [31:0] rd_ctrl = {28'h0, ind_pres_q, fs_only_q, sw_mode_q};
    wire [31:0] rd_oct = {24'h0, oc_cfg_q.dis_ms, oc_cfg_q.en_ms};
    wire [31:0] rd_pwr = {20'h0, qual, 4'h0, power_q};
    wire [31:0] rd_ind = {{(32-4*NPORTS){1'b0}}, indctl_q};
    wire [31:0] rd_st = {24'h0, bab_chg_q, oc_chg_q};
    wire [31:0] rd_hc = {24'h0, ind_pres_q, 5'h0, sw_mode_q}; // RQ11
    always_comb begin
        rdata_d = 32'h0;
        if (REG_RE_I) begin
            unique case (REG_ADDR_I)
                `HPPIC_CTRL_OFS: rdata_d = rd_ctrl;
                `HPPIC_OCTIME_OFS: rdata_d = rd_oct;
                `HPPIC_POWER_OFS: rdata_d = rd_pwr;
                `HPPIC_INDCTL_OFS: rdata_d = rd_ind;
                `HPPIC_STATUS_OFS: rdata_d = rd_st;
                `HPPIC_HUBCHAR_OFS: rdata_d = rd_hc;
                default: rdata_d = 32'h0;
            endcase
        end
    end

    // ============================================================
    // Configuration registers
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            sw_mode_q <= `HPPIC_SW_RESET; // RQ4
            fs_only_q <= 1'b0;
            ind_pres_q <= `HPPIC_INDPRES_RESET; // RQ11
            oc_cfg_q <= {`HPPIC_OC_MS_RESET, `HPPIC_OC_MS_RESET}; // RQ8
            indctl_q <= '0; // RQ14
        end else begin
            if (wr_ctrl) begin
                sw_mode_q <= REG_WDATA_I[`HPPIC_CTRL_SW_MSB:`HPPIC_CTRL_SW_LSB];
                fs_only_q <= REG_WDATA_I[`HPPIC_CTRL_FSONLY];
                ind_pres_q <= REG_WDATA_I[`HPPIC_CTRL_INDPRES];
            end
            if (wr_oct) begin
                oc_cfg_q.en_ms <= REG_WDATA_I[`HPPIC_OCT_EN_MSB:`HPPIC_OCT_EN_LSB]; // RQ9
                oc_cfg_q.dis_ms <= REG_WDATA_I[`HPPIC_OCT_DIS_MSB:`HPPIC_OCT_DIS_LSB];
            end
            if (wr_ind) begin
                indctl_q <= REG_WDATA_I[4*NPORTS-1:0]; // RQ18
            end
        end
    end

    // ============================================================
    // Port control and output registers
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            power_q <= '0; // RQ5
            PORT_POWER_ENABLE_N_O <= {NPORTS{1'b1}};
            oc_amber_q <= '0;
            oc_chg_q <= '0;
            bab_chg_q <= '0;
            qual_q <= '0;
            blocked_q <= '0;
            PORT_DISABLE_O <= '0;
            OC_REPORT_O <= '0;
            US_TX_EN_O <= 1'b0;
            US_HIGH_SPEED_O <= 1'b0;
            REG_RDATA_O <= 32'h0;
        end else begin
            power_q <= power_d;
            PORT_POWER_ENABLE_N_O <= pwr_en_n_d; // RQ6
            oc_amber_q <= amber_d;
            oc_chg_q <= oc_chg_d;
            bab_chg_q <= bab_chg_d;
            qual_q <= qual;
            blocked_q <= blocked_d;
            PORT_DISABLE_O <= bab_dis; // RQ3
            OC_REPORT_O <= oc_chg_d; // RQ10
            US_TX_EN_O <= tx_en_d;
            US_HIGH_SPEED_O <= hs_d;
            REG_RDATA_O <= rdata_d;
        end
    end

    // ============================================================
    // Checks
    oc_power_off_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I) // RQ10
        (|qual_rise && !no_switch) |=>
            (PORT_POWER_ENABLE_N_O & $past(qual_rise)) == $past(qual_rise))
        else $error("qualified overcurrent left port powered");
    gang_equal_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I) // RQ23
        (ganged && $stable(sw_mode_q)) |=> (power_q == '0 || power_q == '1))
        else $error("ganged ports powered unequally");
    babble_disable_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I) // RQ22
        1'b1 |=> PORT_DISABLE_O == $past(BABBLE_I & port_en))
        else $error("babble disable not confined to offending enabled port");
    us_block_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I) // RQ2
        (|(DS_SOURCE_I & bad_now) && DS_SOURCE_I == (DS_SOURCE_I & bad_now)) |=> !US_TX_EN_O)
        else $error("downstream babble reached upstream link");
    hs_sel_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I) // RQ1
        fs_only_q |=> !US_HIGH_SPEED_O)
        else $error("high speed with full speed only set");
    oc_flag_set_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I) // RQ10
        |oc_trip |=> (oc_chg_q & $past(oc_trip)) == $past(oc_trip))
        else $error("overcurrent event lost");
    us_need_conn_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I) // RQ2
        !US_RPT_CONN_I |=> !US_TX_EN_O)
        else $error("upstream transmit without repeater connectivity");
    no_switch_on_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I) // RQ4
        no_switch |=> PORT_POWER_ENABLE_N_O == '0)
        else $error("power enables not asserted without switching");
    hubchar_bit_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I) // RQ11
        (REG_RE_I && REG_ADDR_I == `HPPIC_HUBCHAR_OFS) |=>
            REG_RDATA_O[`HPPIC_HC_IND_BIT] == $past(ind_pres_q))
        else $error("indicator presence bit wrong in characteristics");
    bab_flag_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I) // RQ22
        |bab_dis |=> (bab_chg_q & $past(bab_dis)) == $past(bab_dis))
        else $error("babble disable event lost");
    oc_amber_set_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I) // RQ15
        |oc_trip |=> (oc_amber_q & $past(oc_trip)) == $past(oc_trip))
        else $error("overcurrent amber flag not set");

endmodule

// ---- verification/hppic_sw_model.sv ----
// Behavioural external power switch with open-drain overload flags
module hppic_sw_model (
    input wire logic [3:0] enable_n_i,
    input wire logic [3:0] fault_i,
    output logic [3:0] sense_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Flag pulled high unless a powered port is overloaded
    assign sense_n_o = ~(fault_i & ~enable_n_i);
endmodule

// ---- verification/tb.sv ----
// Self-checking bench for the port power and indicator block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import hppic_pkg::*;
    localparam int TK = 10;
    logic clk, rst_n, we, re, conn, txr, chirp, txen, hs;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    hppic_port_state_e [3:0] st, sr;
    logic [3:0] rreq, bab, disc, src, fault, sense_n, port_power_enable_n, dis, ocr, grn, amb;
    int miscompares, num_checks, p, q, cyc, ms, ng, na, nb;
    int ge[8] = '{0, 0, 2, 1, 0, 1, 0, 0};
    int ae[8] = '{0, 2, 0, 0, 1, 1, 0, 0};

    hppic_top #(.NPORTS(4), .TICK_CYCLES(TK), .BLINK_TICKS(2)) dut_u (
        .CLK_SYS_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WE_I(we), .REG_RE_I(re), .REG_RDATA_O(rdata), .PORT_STATE_I(st),
        .PORT_RESET_REQ_I(rreq), .BABBLE_I(bab), .DS_DISCONNECT_I(disc),
        .DS_SOURCE_I(src), .US_RPT_CONN_I(conn), .US_TX_REQ_I(txr),
        .US_CHIRP_OK_I(chirp), .PORT_OVERCURRENT_SENSE_N_I(sense_n),
        .PORT_POWER_ENABLE_N_O(port_power_enable_n), .PORT_DISABLE_O(dis), .OC_REPORT_O(ocr),
        .US_TX_EN_O(txen), .US_HIGH_SPEED_O(hs), .LED_GREEN_O(grn), .LED_AMBER_O(amb)
    );
    hppic_sw_model sw_u (.enable_n_i(port_power_enable_n), .fault_i(fault), .sense_n_o(sense_n));

    // ============================================================
    // Shared tasks
    task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic cyc_n(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
        #1;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1;
        check("rdata", rdata, e);
    endtask
    // Counts lit cycles; a blink phase is far shorter than the window
    task automatic watch();
        ng = 0;
        na = 0;
        nb = 0;
        repeat (60) begin
            cyc_n(1);
            ng += int'(grn[p] === 1'b1);
            na += int'(amb[p] === 1'b1);
            nb += int'(grn[p] === 1'b1 && amb[p] === 1'b1);
        end
    endtask
    function automatic int cls(int n);
        return (n == 0) ? 0 : ((n == 60) ? 2 : 1);
    endfunction

    // ============================================================
    // Clock, watchdog and main sequence
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        {rst_n, we, re, conn, txr, chirp} = '0;
        {addr, wdata, rreq, bab, disc, src, fault} = '0;
        st = '{default: HPPIC_ST_POWERED_OFF};
        miscompares = 0;
        num_checks = 0;
        void'($urandom(21423));
        p = $urandom % 4;
        q = (p + 1) % 4;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        cyc_n(1);
        check("port_power_enable_n", 32'(port_power_enable_n), 32'hf);
        rd(8'h14, 32'h81);
        rd(8'h3c, 32'h0);
        // Default, shortest and longest qualification intervals
        for (int i = 0; i < 3; i++) begin
            ms = (i == 0) ? 8 : ((i == 1) ? 0 : 15);
            if (i > 0)
                wr(8'h04, 32'(ms * 17));
            wr(8'h08, 32'(1 << p));
            check("port_power_enable_n", 32'(port_power_enable_n), 32'(4'hf ^ 4'(1 << p)));
            @(posedge clk);
            fault[p] <= 1'b1;
            cyc = 0;
            while (port_power_enable_n[p] !== 1'b1 && cyc < 400) begin
                cyc_n(1);
                cyc++;
            end
            check("trip_lo", 32'(cyc >= ms * TK - TK), 32'h1);
            check("trip_hi", 32'(cyc <= ms * TK + TK + 6), 32'h1);
            check("oc_report", 32'(ocr), 32'(1 << p));
            rd(8'h10, 32'(1 << p));
            @(posedge clk);
            fault[p] <= 1'b0;
            wr(8'h10, 32'hf);
        end
        cyc_n(4);
        watch();
        check("oc_amber", 32'(na), 32'd60);
        @(posedge clk);
        st[p] <= HPPIC_ST_ENABLED;
        cyc_n(4);
        watch();
        check("auto_green", 32'(ng), 32'd60);
        @(posedge clk);
        st[p] <= HPPIC_ST_SUSPENDED;
        cyc_n(4);
        watch();
        check("auto_off", 32'(ng + na), 32'd0);
        for (int c = 0; c < 8; c++) begin
            wr(8'h0c, 32'((8 | c) << (4 * p)));
            cyc_n(4);
            watch();
            check("man_green", 32'(cls(ng)), 32'(ge[c]));
            check("man_amber", 32'(cls(na)), 32'(ae[c]));
            check("man_both", 32'(nb), 32'd0);
        end
        wr(8'h0c, 32'h0);
        @(posedge clk);
        st[p] <= HPPIC_ST_INACTIVE;
        rreq[p] <= 1'b1;
        @(posedge clk);
        rreq <= '0;
        cyc_n(4);
        watch();
        check("reset_green", 32'(ng), 32'd60);
        @(posedge clk);
        for (int k = 0; k < 4; k++)
            sr[k] = hppic_port_state_e'($urandom % 4);
        sr[p] = HPPIC_ST_ENABLED;
        st <= sr;
        {conn, txr} <= 2'b11;
        src <= 4'(1 << p);
        cyc_n(3);
        check("tx_en", 32'(txen), 32'h1);
        @(posedge clk);
        bab[p] <= 1'b1;
        @(posedge clk);
        bab <= '0;
        #1;
        check("disable", 32'(dis), 32'(1 << p));
        cyc_n(2);
        check("disable_once", 32'(dis), 32'h0);
        check("tx_blocked", 32'(txen), 32'h0);
        rd(8'h10, 32'(16 << p));
        wr(8'h0c, 32'(11 << (4 * p)));
        cyc_n(4);
        watch();
        check("babble_blink", 32'(cls(ng)), 32'd1);
        @(posedge clk);
        src <= 4'(1 << q);
        cyc_n(3);
        check("tx_other", 32'(txen), 32'h1);
        @(posedge clk);
        disc[q] <= 1'b1;
        @(posedge clk);
        disc <= '0;
        cyc_n(2);
        check("tx_disc", 32'(txen), 32'h0);
        @(posedge clk);
        chirp <= 1'b1;
        cyc_n(3);
        check("high_speed", 32'(hs), 32'h1);
        wr(8'h00, 32'h0d);
        cyc_n(2);
        check("full_speed", 32'(hs), 32'h0);
        wr(8'h00, 32'h05);
        cyc_n(2);
        check("no_leds", 32'({grn, amb}), 32'h0);
        rd(8'h14, 32'h01);
        wr(8'h00, 32'h08);
        wr(8'h08, 32'h1);
        check("gang_on", 32'(port_power_enable_n), 32'h0);
        wr(8'h08, 32'(16 << q));
        check("gang_off", 32'(port_power_enable_n), 32'hf);
        wr(8'h00, 32'h0a);
        cyc_n(1);
        check("no_switch", 32'(port_power_enable_n), 32'h0);
        tally_and_finish();
    end
endmodule
